/* sim/iam_matcher_tb.sv */
/*
 * Self-checking testbench of the IPv4 access_control_entry matcher.
 * Assumes the matcher answers one cycle after each hdr_valid pulse and
 * holds its own assertions; the hit counter is built 2 bits wide here.
 */
`timescale 1ns/1ps

module iam_matcher_tb;

    // ==========================================================================
    // Signals
    logic              clk;
    logic              srst;
    logic              entry_enable;
    iam_pkg::iam_cfg_t cfg;
    logic              hdr_valid;
    iam_pkg::iam_hdr_t hdr;
    logic              l4_sub_match;
    logic              hit_count_clear;
    logic              match_valid;
    logic              match_hit;
    logic [5:0]        crit_match;
    logic [1:0]        hit_count;
    logic [1:0]        exp_cnt;
    int                n_mismatch;
    int                samples_checked;

    // A narrow counter lets saturation be reached in three hits.
    iam_matcher #(.HIT_CNT_W(2)) u_iam_matcher (
        .clk             (clk),
        .srst            (srst),
        .entry_enable    (entry_enable),
        .cfg             (cfg),
        .hdr_valid       (hdr_valid),
        .hdr             (hdr),
        .l4_sub_match    (l4_sub_match),
        .hit_count_clear (hit_count_clear),
        .match_valid     (match_valid),
        .match_hit       (match_hit),
        .crit_match      (crit_match),
        .hit_count       (hit_count)
    );

    // 100 ns clock period.
    always #50 clk = ~clk;

    // ==========================================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Base entry: IPv4 with every criterion at any, and a plain TCP header.
    task automatic base();
        cfg = '0;
        cfg.frame_sel = iam_pkg::IAM_FRAME_IPV4;
        hdr = '0;
        hdr.kind = iam_pkg::IAM_KIND_IPV4;
        hdr.protocol = 8'h06;
        hdr.ttl = 8'h40;
        hdr.src_addr = 32'h0a000001;
        hdr.dst_addr = 32'hc0a80001;
        entry_enable = 1'b1;
        l4_sub_match = 1'b1;
    endtask

    // One header pulse; the result is judged the cycle after it is taken.
    task automatic run(input logic h, input logic [5:0] c);
        @(negedge clk);
        chk(match_valid, 1'b0);
        hdr_valid = 1'b1;
        @(negedge clk);
        hdr_valid = 1'b0;
        chk(match_valid, 1'b1);
        chk(match_hit, h);
        chk(crit_match, c);
        if (h && exp_cnt != 2'h3) exp_cnt++;
    endtask

    task automatic done(input string name);
        @(negedge clk);
        chk(hit_count, exp_cnt);
        $display("test %s finished", name);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        chk({match_valid, match_hit, crit_match, hit_count}, 10'h000);
        done("reset");
    endtask

    task automatic t_frame();
        base(); run(1'b1, 6'h3f);
        cfg.frame_sel = iam_pkg::IAM_FRAME_ARP; run(1'b0, 6'h3f);
        cfg.frame_sel = iam_pkg::IAM_FRAME_IPV6; run(1'b0, 6'h3f);
        base(); hdr.kind = iam_pkg::IAM_KIND_IPV6; run(1'b0, 6'h3f);
        base(); hdr.kind = iam_pkg::IAM_KIND_OTHER; run(1'b0, 6'h3f);
        base(); entry_enable = 1'b0; run(1'b0, 6'h3f);
        done("frame");
    endtask

    // The flipped number of one protocol is another's (ICMP to UDP and back).
    task automatic l4_case(input iam_pkg::iam_proto_sel_t s, input logic [7:0] n);
        base(); cfg.proto_sel = s; hdr.protocol = n; run(1'b1, 6'h3f);
        l4_sub_match = 1'b0; run(1'b0, 6'h3e);
        l4_sub_match = 1'b1; hdr.protocol = n ^ 8'h10; run(1'b0, 6'h3e);
    endtask

    task automatic t_proto();
        base(); hdr.protocol = 8'hff; run(1'b1, 6'h3f);
        cfg.proto_sel = iam_pkg::IAM_PROTO_SPECIFIC; cfg.proto_value = 8'hff; run(1'b1, 6'h3f);
        hdr.protocol = 8'hfe; run(1'b0, 6'h3e);
        cfg.proto_value = 8'h00; hdr.protocol = 8'h00; run(1'b1, 6'h3f);
        l4_case(iam_pkg::IAM_PROTO_ICMP, iam_pkg::IAM_PROTO_NUM_ICMP);
        l4_case(iam_pkg::IAM_PROTO_UDP, iam_pkg::IAM_PROTO_NUM_UDP);
        l4_case(iam_pkg::IAM_PROTO_TCP, iam_pkg::IAM_PROTO_NUM_TCP);
        done("protocol");
    endtask

    task automatic t_ttl();
        base(); cfg.ttl_sel = iam_pkg::IAM_TTL_ZERO; hdr.ttl = 8'h00; run(1'b1, 6'h3f);
        hdr.ttl = 8'h01; run(1'b0, 6'h3d);
        cfg.ttl_sel = iam_pkg::IAM_TTL_NONZERO; run(1'b1, 6'h3f);
        hdr.ttl = 8'h00; run(1'b0, 6'h3d);
        cfg.ttl_sel = iam_pkg::IAM_TTL_ANY; run(1'b1, 6'h3f);
        done("ttl");
    endtask

    task automatic t_frag();
        base(); cfg.frag_sel = iam_pkg::IAM_TRI_NO; run(1'b1, 6'h3f);
        hdr.more_frag = 1'b1; run(1'b0, 6'h3b);
        hdr.more_frag = 1'b0; hdr.frag_offset = 13'h0001; run(1'b0, 6'h3b);
        cfg.frag_sel = iam_pkg::IAM_TRI_YES; run(1'b1, 6'h3f);
        hdr.frag_offset = 13'h0000; run(1'b0, 6'h3b);
        cfg.frag_sel = iam_pkg::IAM_TRI_ANY; hdr.frag_offset = 13'h1fff; run(1'b1, 6'h3f);
        done("fragment");
    endtask

    task automatic t_opt();
        base(); cfg.opt_sel = iam_pkg::IAM_TRI_YES; hdr.has_options = 1'b1; run(1'b1, 6'h3f);
        hdr.has_options = 1'b0; run(1'b0, 6'h37);
        cfg.opt_sel = iam_pkg::IAM_TRI_NO; run(1'b1, 6'h3f);
        hdr.has_options = 1'b1; run(1'b0, 6'h37);
        cfg.opt_sel = iam_pkg::IAM_TRI_ANY; run(1'b1, 6'h3f);
        done("options");
    endtask

    // Sets the configured filter and the frame address of one side.
    task automatic aset(input bit d, input iam_pkg::iam_addr_sel_t s, input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] f);
        if (d) begin
            cfg.dst_sel = s; cfg.dst_addr = a; cfg.dst_mask = m; hdr.dst_addr = f;
        end else begin
            cfg.src_sel = s; cfg.src_addr = a; cfg.src_mask = m; hdr.src_addr = f;
        end
    endtask

    task automatic addr_case(input bit d);
        logic [5:0] c;
        c = d ? 6'h1f : 6'h2f;
        base(); aset(d, iam_pkg::IAM_ADDR_HOST, 32'hc0a80a05, '0, 32'hc0a80a05); run(1'b1, 6'h3f);
        aset(d, iam_pkg::IAM_ADDR_HOST, 32'hc0a80a05, '0, 32'hc0a80a04); run(1'b0, c);
        aset(d, iam_pkg::IAM_ADDR_NETWORK, 32'hc0a80a05, 32'hffffff00, 32'hc0a80afa); run(1'b1, 6'h3f);
        aset(d, iam_pkg::IAM_ADDR_NETWORK, 32'hc0a80a05, 32'hffffff00, 32'hc0a80b05); run(1'b0, c);
        aset(d, iam_pkg::IAM_ADDR_NETWORK, 32'hc0a80a05, 32'h00000000, 32'h3f57f5fa); run(1'b1, 6'h3f);
        aset(d, iam_pkg::IAM_ADDR_ANY, 32'hc0a80a05, 32'hffffffff, 32'h3f57f5fa); run(1'b1, 6'h3f);
    endtask

    task automatic t_addr();
        addr_case(1'b0);
        addr_case(1'b1);
        done("address");
    endtask

    // Clears the count, drives it past its top without checking it there, then
    // clears it in the very cycle of a hit, which must leave a count of one.
    task automatic t_count();
        hit_count_clear = 1'b1;
        @(negedge clk);
        hit_count_clear = 1'b0;
        exp_cnt = 2'h0;
        chk(hit_count, 2'h0);
        base();
        repeat (5) run(1'b1, 6'h3f);
        hit_count_clear = 1'b1;
        @(negedge clk);
        hit_count_clear = 1'b0;
        chk(hit_count, 2'h1);
        exp_cnt = 2'h1;
        done("counter");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================================
    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial begin
        clk = 1'b0; srst = 1'b1; hdr_valid = 1'b0; hit_count_clear = 1'b0;
        exp_cnt = 2'h0; n_mismatch = 0; samples_checked = 0;
        base();
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_reset(); t_frame(); t_proto(); t_ttl(); t_frag(); t_opt(); t_addr(); t_count();
        conclude();
    end

    // Watchdog: the tests need about 135 cycles, so 2000 means a hang.
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

endmodule

/* src/iam_addr_filter.sv */
/*
 * Address filter of one access_control_entry: any, host or masked network.
 * Purely combinational; the instantiating matcher registers the result.
 */
`timescale 1ns/1ps

module iam_addr_filter (
    // Configuration
    input  wire iam_pkg::iam_addr_sel_t         sel,
    input  wire logic [iam_pkg::IAM_ADDR_W-1:0] cfg_addr,
    input  wire logic [iam_pkg::IAM_ADDR_W-1:0] cfg_mask,
    // Frame field
    input  wire logic [iam_pkg::IAM_ADDR_W-1:0] frame_addr,
    // Result
    output logic                                match
);

    // ==========================================================================
    // Compare
    // A mask bit of zero makes that address bit a don't-care in network mode.
    always_comb begin
        case (sel)
            iam_pkg::IAM_ADDR_ANY:     match = 1'b1;
            iam_pkg::IAM_ADDR_HOST:    match = (frame_addr == cfg_addr);
            iam_pkg::IAM_ADDR_NETWORK: match = ((frame_addr ^ cfg_addr) & cfg_mask) == '0;
            default:                   match = 1'b0;
        endcase
    end

endmodule

/* src/iam_matcher.sv */
/*
 * Matcher of the IPv4 criteria of one access_control_entry, with a
 * per-criterion status vector and a saturating hit counter.
 * Assumes a parser on the same clock that presents one header per
 * hdr_valid cycle, and external logic that judges the ICMP, UDP and TCP
 * sub-criteria and reports them on l4_sub_match in the same cycle.
 */
// Contract
// - IPv4 criteria apply only to IPv4 entries.
// - Protocol any ignores the protocol number.
// - Protocol specific needs equal configured number.
// - ICMP, UDP, TCP need protocol and sub-criteria.
// - TTL zero rejects positive TTL; any ignores.
// - TTL non-zero lets positive TTL match.
// - Fragment no rejects fragments; any ignores.
// - Fragment yes lets fragments match.
// - Options yes lets options match; any ignores.
// - Source any ignores source address.
// - Source host needs exact source address.
// - Source network compares under source mask.
// - Destination any ignores destination address.
// - Destination host needs exact destination address.
// - Destination network compares under destination mask.
`timescale 1ns/1ps

module iam_matcher #(
    parameter int HIT_CNT_W = 16
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // Entry configuration
    input  wire logic                              entry_enable,
    input  wire iam_pkg::iam_cfg_t                 cfg,
    // Parsed header
    input  wire logic                              hdr_valid,
    input  wire iam_pkg::iam_hdr_t                 hdr,
    input  wire logic                              l4_sub_match,
    // Status control
    input  wire logic                              hit_count_clear,
    // Result
    output logic                                   match_valid,
    output logic                                   match_hit,
    output logic [iam_pkg::IAM_CRIT_N-1:0]         crit_match,
    output logic [HIT_CNT_W-1:0]                   hit_count
);

    // ==========================================================================
    // Decoding helpers
    // Three-way flag test shared by the fragment and the options criteria.
    function automatic logic tri_match(input iam_pkg::iam_tri_sel_t sel, input logic flag);
        case (sel)
            iam_pkg::IAM_TRI_ANY: tri_match = 1'b1;
            iam_pkg::IAM_TRI_NO:  tri_match = ~flag;
            iam_pkg::IAM_TRI_YES: tri_match = flag;
            default:              tri_match = 1'b0;
        endcase
    endfunction

    // ==========================================================================
    // Declarations
    logic                          match_valid_reg;
    logic                          match_valid_next;
    logic                          match_hit_reg;
    logic                          match_hit_next;
    logic [iam_pkg::IAM_CRIT_N-1:0] crit_reg;
    logic [iam_pkg::IAM_CRIT_N-1:0] crit_next;
    logic [HIT_CNT_W-1:0]          hit_count_reg;
    logic [HIT_CNT_W-1:0]          hit_count_next;
    logic                          ipv4_gate;
    logic                          is_fragment;
    logic                          proto_ok;
    logic                          ttl_ok;
    logic                          src_ok;
    logic                          dst_ok;

    // ==========================================================================
    // Gate
    // An entry that selects another frame type never lets this logic decide.
    assign ipv4_gate = entry_enable && (cfg.frame_sel == iam_pkg::IAM_FRAME_IPV4) &&
                       (hdr.kind == iam_pkg::IAM_KIND_IPV4);

    // A frame counts as a fragment on either the flag or a nonzero offset.
    assign is_fragment = hdr.more_frag || (hdr.frag_offset != '0);

    // ==========================================================================
    // Protocol criterion
    // The sub-criteria are judged outside; this block only folds them in.
    always_comb begin
        case (cfg.proto_sel)
            iam_pkg::IAM_PROTO_ANY:      proto_ok = 1'b1;
            iam_pkg::IAM_PROTO_SPECIFIC: proto_ok = (hdr.protocol == cfg.proto_value);
            iam_pkg::IAM_PROTO_ICMP:     proto_ok = (hdr.protocol == iam_pkg::IAM_PROTO_NUM_ICMP) &&
                                                    l4_sub_match;
            iam_pkg::IAM_PROTO_UDP:      proto_ok = (hdr.protocol == iam_pkg::IAM_PROTO_NUM_UDP) &&
                                                    l4_sub_match;
            iam_pkg::IAM_PROTO_TCP:      proto_ok = (hdr.protocol == iam_pkg::IAM_PROTO_NUM_TCP) &&
                                                    l4_sub_match;
            default:                     proto_ok = 1'b0;
        endcase
    end

    // ==========================================================================
    // Time-to-live criterion
    // Zero mode accepts only a TTL of zero; non-zero mode only a positive one.
    always_comb begin
        case (cfg.ttl_sel)
            iam_pkg::IAM_TTL_ANY:     ttl_ok = 1'b1;
            iam_pkg::IAM_TTL_ZERO:    ttl_ok = (hdr.ttl == '0);
            iam_pkg::IAM_TTL_NONZERO: ttl_ok = (hdr.ttl != '0);
            default:                  ttl_ok = 1'b0;
        endcase
    end

    // ==========================================================================
    // Address criteria
    iam_addr_filter u_src_filter (
        .sel        (cfg.src_sel),
        .cfg_addr   (cfg.src_addr),
        .cfg_mask   (cfg.src_mask),
        .frame_addr (hdr.src_addr),
        .match      (src_ok)
    );

    iam_addr_filter u_dst_filter (
        .sel        (cfg.dst_sel),
        .cfg_addr   (cfg.dst_addr),
        .cfg_mask   (cfg.dst_mask),
        .frame_addr (hdr.dst_addr),
        .match      (dst_ok)
    );

    // ==========================================================================
    // Result next values
    // The status vector is captured for every header so software can see why
    // an entry missed; the hit itself also needs the IPv4 gate.
    always_comb begin
        match_valid_next = hdr_valid;
        match_hit_next   = 1'b0;
        crit_next        = crit_reg;
        if (hdr_valid) begin
            crit_next[iam_pkg::IAM_CRIT_PROTO] = proto_ok;
            crit_next[iam_pkg::IAM_CRIT_TTL]   = ttl_ok;
            crit_next[iam_pkg::IAM_CRIT_FRAG]  = tri_match(cfg.frag_sel, is_fragment);
            crit_next[iam_pkg::IAM_CRIT_OPT]   = tri_match(cfg.opt_sel, hdr.has_options);
            crit_next[iam_pkg::IAM_CRIT_SRC]   = src_ok;
            crit_next[iam_pkg::IAM_CRIT_DST]   = dst_ok;
            match_hit_next = ipv4_gate && proto_ok && ttl_ok && src_ok && dst_ok &&
                             tri_match(cfg.frag_sel, is_fragment) &&
                             tri_match(cfg.opt_sel, hdr.has_options);
        end
    end

    // ==========================================================================
    // Hit counter next value
    // A hit in the clear cycle is kept, so the count restarts at one; the
    // counter saturates instead of wrapping so a busy entry never reads low.
    always_comb begin
        hit_count_next = hit_count_reg;
        if (hit_count_clear) begin
            hit_count_next = '0;
        end
        if (match_valid_reg && match_hit_reg) begin
            if (hit_count_clear) begin
                hit_count_next = {{(HIT_CNT_W-1){1'b0}}, 1'b1};
            end else if (hit_count_reg != {HIT_CNT_W{1'b1}}) begin
                hit_count_next = hit_count_reg + {{(HIT_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ==========================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            match_valid_reg <= 1'b0;
            match_hit_reg   <= 1'b0;
            crit_reg        <= iam_pkg::IAM_CRIT_RST;
            hit_count_reg   <= '0;
        end else begin
            match_valid_reg <= match_valid_next;
            match_hit_reg   <= match_hit_next;
            crit_reg        <= crit_next;
            hit_count_reg   <= hit_count_next;
        end
    end

    // ==========================================================================
    // Outputs
    assign match_valid = match_valid_reg;
    assign match_hit   = match_hit_reg;
    assign crit_match  = crit_reg;
    assign hit_count   = hit_count_reg;

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (srst);

    // A header that this entry must judge as IPv4.
    sequence s_ipv4_frame;
        hdr_valid && entry_enable && (cfg.frame_sel == iam_pkg::IAM_FRAME_IPV4) &&
            (hdr.kind == iam_pkg::IAM_KIND_IPV4);
    endsequence

    // The answer one cycle later with every criterion passing.
    sequence s_all_pass;
        match_valid && (&crit_match);
    endsequence

    property p_all_pass_hits;
        s_ipv4_frame ##1 s_all_pass |-> match_hit;
    endproperty

    a_frame_type_gate: assert property (hdr_valid && (cfg.frame_sel != iam_pkg::IAM_FRAME_IPV4)
        |=> match_valid && !match_hit)
        else $error("Hit reported for an entry that does not select IPv4.");

    a_entry_kind_gate: assert property (hdr_valid && (!entry_enable || (hdr.kind != iam_pkg::IAM_KIND_IPV4))
        |=> match_valid && !match_hit)
        else $error("Hit reported for a disabled entry or a non-IPv4 frame.");

    a_proto_any_pass: assert property (hdr_valid && (cfg.proto_sel == iam_pkg::IAM_PROTO_ANY)
        |=> crit_match[iam_pkg::IAM_CRIT_PROTO])
        else $error("Protocol any did not pass.");

    a_proto_specific_eq: assert property (hdr_valid && (cfg.proto_sel == iam_pkg::IAM_PROTO_SPECIFIC)
        |=> crit_match[iam_pkg::IAM_CRIT_PROTO] == ($past(hdr.protocol) == $past(cfg.proto_value)))
        else $error("Specific protocol compare is wrong.");

    a_proto_l4_sub: assert property (hdr_valid && (cfg.proto_sel == iam_pkg::IAM_PROTO_TCP)
        |=> crit_match[iam_pkg::IAM_CRIT_PROTO] ==
            (($past(hdr.protocol) == iam_pkg::IAM_PROTO_NUM_TCP) && $past(l4_sub_match)))
        else $error("TCP selection ignored protocol or sub-criteria.");

    a_proto_l4_icmp: assert property (hdr_valid && (cfg.proto_sel == iam_pkg::IAM_PROTO_ICMP)
        |=> crit_match[iam_pkg::IAM_CRIT_PROTO] ==
            (($past(hdr.protocol) == iam_pkg::IAM_PROTO_NUM_ICMP) && $past(l4_sub_match)))
        else $error("ICMP selection ignored protocol or sub-criteria.");

    a_proto_l4_udp: assert property (hdr_valid && (cfg.proto_sel == iam_pkg::IAM_PROTO_UDP)
        |=> crit_match[iam_pkg::IAM_CRIT_PROTO] ==
            (($past(hdr.protocol) == iam_pkg::IAM_PROTO_NUM_UDP) && $past(l4_sub_match)))
        else $error("UDP selection ignored protocol or sub-criteria.");

    a_ttl_zero_block: assert property (hdr_valid && (cfg.ttl_sel == iam_pkg::IAM_TTL_ZERO) && (hdr.ttl != '0)
        |=> !crit_match[iam_pkg::IAM_CRIT_TTL] && !match_hit)
        else $error("TTL zero mode passed a positive TTL.");

    a_ttl_nonzero_pass: assert property (hdr_valid && (cfg.ttl_sel == iam_pkg::IAM_TTL_NONZERO)
        |=> crit_match[iam_pkg::IAM_CRIT_TTL] == ($past(hdr.ttl) != '0))
        else $error("TTL non-zero mode judged wrongly.");

    a_frag_no_block: assert property (hdr_valid && (cfg.frag_sel == iam_pkg::IAM_TRI_NO) && is_fragment
        |=> !crit_match[iam_pkg::IAM_CRIT_FRAG] && !match_hit)
        else $error("Fragment no mode passed a fragment.");

    a_frag_yes_pass: assert property (hdr_valid && (cfg.frag_sel == iam_pkg::IAM_TRI_YES) && is_fragment
        |=> crit_match[iam_pkg::IAM_CRIT_FRAG])
        else $error("Fragment yes mode rejected a fragment.");

    a_opt_yes_pass: assert property (hdr_valid && (cfg.opt_sel == iam_pkg::IAM_TRI_YES)
        |=> crit_match[iam_pkg::IAM_CRIT_OPT] == $past(hdr.has_options))
        else $error("Options yes mode judged wrongly.");

    a_opt_no_block: assert property (hdr_valid && (cfg.opt_sel == iam_pkg::IAM_TRI_NO) && hdr.has_options
        |=> !crit_match[iam_pkg::IAM_CRIT_OPT] && !match_hit)
        else $error("Options no mode passed a frame with options.");

    a_src_any_pass: assert property (hdr_valid && (cfg.src_sel == iam_pkg::IAM_ADDR_ANY)
        |=> crit_match[iam_pkg::IAM_CRIT_SRC])
        else $error("Source any did not pass.");

    a_src_host_eq: assert property (hdr_valid && (cfg.src_sel == iam_pkg::IAM_ADDR_HOST)
        |=> crit_match[iam_pkg::IAM_CRIT_SRC] == ($past(hdr.src_addr) == $past(cfg.src_addr)))
        else $error("Source host compare is wrong.");

    a_src_net_mask: assert property (hdr_valid && (cfg.src_sel == iam_pkg::IAM_ADDR_NETWORK)
        |=> crit_match[iam_pkg::IAM_CRIT_SRC] ==
            ((($past(hdr.src_addr) ^ $past(cfg.src_addr)) & $past(cfg.src_mask)) == '0))
        else $error("Source network compare is wrong.");

    a_dst_any_pass: assert property (hdr_valid && (cfg.dst_sel == iam_pkg::IAM_ADDR_ANY)
        |=> crit_match[iam_pkg::IAM_CRIT_DST])
        else $error("Destination any did not pass.");

    a_dst_host_eq: assert property (hdr_valid && (cfg.dst_sel == iam_pkg::IAM_ADDR_HOST)
        |=> crit_match[iam_pkg::IAM_CRIT_DST] == ($past(hdr.dst_addr) == $past(cfg.dst_addr)))
        else $error("Destination host compare is wrong.");

    a_dst_net_mask: assert property (hdr_valid && (cfg.dst_sel == iam_pkg::IAM_ADDR_NETWORK)
        |=> crit_match[iam_pkg::IAM_CRIT_DST] ==
            ((($past(hdr.dst_addr) ^ $past(cfg.dst_addr)) & $past(cfg.dst_mask)) == '0))
        else $error("Destination network compare is wrong.");

    a_hit_needs_all: assert property (match_hit |-> match_valid && (&crit_match))
        else $error("Hit reported while a criterion failed.");

    a_all_pass_hit: assert property (p_all_pass_hits)
        else $error("IPv4 frame passing every criterion did not hit.");

    a_count_follows: assert property (match_valid && match_hit && !hit_count_clear &&
        (hit_count != {HIT_CNT_W{1'b1}}) |=> hit_count == $past(hit_count) + {{(HIT_CNT_W-1){1'b0}}, 1'b1})
        else $error("Hit counter did not advance on a hit.");

    // A hit that meets a clear must not be lost, so the count restarts at one.
    a_count_clear_hit: assert property (hit_count_clear && match_valid && match_hit
        |=> hit_count == {{(HIT_CNT_W-1){1'b0}}, 1'b1})
        else $error("Hit in the clear cycle was lost.");

    a_count_clear: assert property (hit_count_clear && !(match_valid && match_hit) |=> hit_count == '0)
        else $error("Hit counter did not clear.");

endmodule

/* src/iam_pkg.sv */
/*
 * Shared types and constants of the IPv4 access control entry matcher:
 * field widths, criterion selections, the parsed header carrier and the
 * configuration carrier of one access_control_entry.
 * Assumes a frame parser that presents already extracted IPv4 header fields.
 */
package iam_pkg;

    // ==========================================================================
    // Field widths
    localparam int IAM_ADDR_W     = 32;
    localparam int IAM_PROTO_W    = 8;
    localparam int IAM_TTL_W      = 8;
    localparam int IAM_FRAG_OFS_W = 13;

    // ==========================================================================
    // Protocol numbers of the three protocols with their own sub-criteria
    localparam logic [IAM_PROTO_W-1:0] IAM_PROTO_NUM_ICMP = 8'h01;
    localparam logic [IAM_PROTO_W-1:0] IAM_PROTO_NUM_TCP  = 8'h06;
    localparam logic [IAM_PROTO_W-1:0] IAM_PROTO_NUM_UDP  = 8'h11;

    // ==========================================================================
    // Positions in the per-criterion match vector
    localparam int IAM_CRIT_PROTO = 0;
    localparam int IAM_CRIT_TTL   = 1;
    localparam int IAM_CRIT_FRAG  = 2;
    localparam int IAM_CRIT_OPT   = 3;
    localparam int IAM_CRIT_SRC   = 4;
    localparam int IAM_CRIT_DST   = 5;
    localparam int IAM_CRIT_N     = 6;

    // ==========================================================================
    // Reset values
    localparam logic [IAM_CRIT_N-1:0] IAM_CRIT_RST = 6'h00;

    // ==========================================================================
    // Selections
    typedef enum logic [2:0] {
        IAM_FRAME_ANY,
        IAM_FRAME_ETHTYPE,
        IAM_FRAME_ARP,
        IAM_FRAME_IPV4,
        IAM_FRAME_IPV6
    } iam_frame_sel_t;

    typedef enum logic [1:0] {
        IAM_KIND_OTHER,
        IAM_KIND_ARP,
        IAM_KIND_IPV4,
        IAM_KIND_IPV6
    } iam_frame_kind_t;

    typedef enum logic [2:0] {
        IAM_PROTO_ANY,
        IAM_PROTO_SPECIFIC,
        IAM_PROTO_ICMP,
        IAM_PROTO_UDP,
        IAM_PROTO_TCP
    } iam_proto_sel_t;

    typedef enum logic [1:0] {
        IAM_TTL_ANY,
        IAM_TTL_ZERO,
        IAM_TTL_NONZERO
    } iam_ttl_sel_t;

    typedef enum logic [1:0] {
        IAM_TRI_ANY,
        IAM_TRI_NO,
        IAM_TRI_YES
    } iam_tri_sel_t;

    typedef enum logic [1:0] {
        IAM_ADDR_ANY,
        IAM_ADDR_HOST,
        IAM_ADDR_NETWORK
    } iam_addr_sel_t;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        iam_frame_kind_t           kind;
        logic [IAM_PROTO_W-1:0]    protocol;
        logic [IAM_TTL_W-1:0]      ttl;
        logic                      more_frag;
        logic [IAM_FRAG_OFS_W-1:0] frag_offset;
        logic                      has_options;
        logic [IAM_ADDR_W-1:0]     src_addr;
        logic [IAM_ADDR_W-1:0]     dst_addr;
    } iam_hdr_t;

    typedef struct packed {
        iam_frame_sel_t         frame_sel;
        iam_proto_sel_t         proto_sel;
        logic [IAM_PROTO_W-1:0] proto_value;
        iam_ttl_sel_t           ttl_sel;
        iam_tri_sel_t           frag_sel;
        iam_tri_sel_t           opt_sel;
        iam_addr_sel_t          src_sel;
        logic [IAM_ADDR_W-1:0]  src_addr;
        logic [IAM_ADDR_W-1:0]  src_mask;
        iam_addr_sel_t          dst_sel;
        logic [IAM_ADDR_W-1:0]  dst_addr;
        logic [IAM_ADDR_W-1:0]  dst_mask;
    } iam_cfg_t;

endpackage
